/* File: logic/dac_cmd_port.v */
/*
 * Serial command and register port of a loop-powered 16-bit current DAC.
 * Frame-sync, serial clock and serial data come from a host on pins and
 * are resynchronised to ref_clk_i; the serial clock must run well below
 * a quarter of the reference rate. Analog blocks (DAC core, ADC, fault
 * detectors) sit outside and are reached through plain ports.
 */
`timescale 1ns/1ps
`include "dac_port_defines.vh"

module dac_cmd_port #(
    parameter [`WDOG_W-1:0] WDOG_CYCLES = `WDOG_CYCLES
) (
    input wire ref_clk_i,
    input wire rst_i,
    input wire sclk_i,
    input wire sync_n_i,
    input wire serial_in_line_i,
    input wire [5:0] fault_flags_i,
    input wire [7:0] adc_code_i,
    input wire adc_done_i,
    output reg serial_out_line_o,
    output reg fault_o,
    output reg [15:0] dac_code_o,
    output reg [15:0] offset_active_o,
    output reg [15:0] gain_active_o,
    output reg [15:0] ctrl_o,
    output reg alarm_o,
    output reg adc_start_o,
    output reg adc_power_o,
    output reg adc_source_o
);

    // CRC over command and data, MSB first
    function [7:0] crc8;
        input [23:0] d;
        integer i;
        reg [7:0] c;
        begin
            c = `CRC_INIT;
            for (i = 23; i >= 0; i = i - 1) begin
                c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? `CRC_POLY : 8'h00);
            end
            crc8 = c;
        end
    endfunction

    // Pin synchronisers; first stages feed only the second stages
    reg sclk_m, sclk_s, sclk_d;
    reg sync_m, sync_s, sync_d;
    reg serin_m, serin_s;
    reg done_m, done_s, done_d;
    reg [5:0] flags_m, flags_s;
    reg [7:0] adc_m, adc_s;

    // Reset values match the idle pin levels, so no false frame edge follows
    // reset; the serial clock resets low, which can only fake a rising edge,
    // and rising edges of the serial clock are never used
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            sclk_m <= 1'b0;
            sclk_s <= 1'b0;
            sclk_d <= 1'b0;
            sync_m <= 1'b1;
            sync_s <= 1'b1;
            sync_d <= 1'b1;
            serin_m <= 1'b0;
            serin_s <= 1'b0;
            done_m <= 1'b0;
            done_s <= 1'b0;
            done_d <= 1'b0;
            flags_m <= 6'h00;
            flags_s <= 6'h00;
            adc_m <= 8'h00;
            adc_s <= 8'h00;
        end else begin
            sclk_m <= sclk_i;
            sclk_s <= sclk_m;
            sclk_d <= sclk_s;
            sync_m <= sync_n_i;
            sync_s <= sync_m;
            sync_d <= sync_s;
            serin_m <= serial_in_line_i;
            serin_s <= serin_m;
            done_m <= adc_done_i;
            done_s <= done_m;
            done_d <= done_s;
            flags_m <= fault_flags_i;
            flags_s <= flags_m;
            adc_m <= adc_code_i;
            adc_s <= adc_m;
        end
    end

    // Edge events in the reference domain
    wire sclk_fall = sclk_d & ~sclk_s;
    wire sync_fall = sync_d & ~sync_s;
    wire sync_rise = ~sync_d & sync_s;
    wire in_frame = ~sync_s;
    wire adc_done = done_s & ~done_d;

    // Registers and frame state
    reg [31:0] shift_r;
    reg [5:0] count_r;
    reg [23:0] out_r;
    reg [15:0] dac_r, ctrl_r, offs_r, gain_r;
    reg [15:0] rd_word_r;
    reg rd_pend_r;
    reg [7:0] adc_r;
    reg crc_err_r;
    reg wdog_r;
    reg [`WDOG_W-1:0] wdog_cnt_r;

    // Frame decode at frame-sync rising
    // Only exact lengths execute; the count saturates above 32 so an
    // overlong frame can never wrap back into a legal length
    wire len24 = (count_r == `FRAME_BITS);
    wire len32 = (count_r == `FRAME_CRC_BITS);
    wire [23:0] body = len32 ? shift_r[31:8] : shift_r[23:0];
    wire [7:0] cmd = body[`CMD_HI:`CMD_LO];
    wire [15:0] data = body[`DATA_HI:`DATA_LO];
    wire crc_ok = (crc8(body) == shift_r[7:0]);
    wire frame_ok = sync_rise & (len24 | (len32 & crc_ok));
    wire crc_bad = sync_rise & len32 & ~crc_ok;
    wire [15:0] fault_word = {crc_err_r, wdog_r, flags_s, adc_r};
    // Conversion start for the power output, decoded like the strobe so that
    // power is already up in the cycle in which the strobe is seen
    wire start_nxt = frame_ok & ((cmd == `CMD_MEASURE) |
        (~ctrl_r[`CTRL_AUTO_RB_DIS] & ctrl_r[`CTRL_ADC_PWR]));

    // Readback mux for read commands
    reg [15:0] rd_sel;
    always @* begin
        case (cmd)
            `CMD_RD_DAC: rd_sel = dac_r;
            `CMD_RD_CTRL: rd_sel = ctrl_r;
            `CMD_RD_OFFS: rd_sel = offs_r;
            `CMD_RD_GAIN: rd_sel = gain_r;
            `CMD_RD_FAULT: rd_sel = fault_word;
            // Unknown read codes return zero, never a stale word
            default: rd_sel = 16'h0000;
        endcase
    end
    wire is_read = (cmd == `CMD_RD_DAC) | (cmd == `CMD_RD_CTRL) |
        (cmd == `CMD_RD_OFFS) | (cmd == `CMD_RD_GAIN) | (cmd == `CMD_RD_FAULT);

    // Input shift and serial output; both move only inside a frame,
    // so a gated serial clock needs no edges outside frames
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            shift_r <= 32'h00000000;
            count_r <= 6'd0;
            out_r <= 24'h000000;
            serial_out_line_o <= 1'b0;
        end else if (sync_fall) begin
            count_r <= 6'd0;
            // Auto mode returns the fault register every frame
            // Words are 16 bits, so the first eight bits out are zero
            if (!ctrl_r[`CTRL_AUTO_RB_DIS])
                out_r <= {8'h00, fault_word};
            else if (rd_pend_r)
                out_r <= {8'h00, rd_word_r};
            else
                out_r <= 24'h000000;
            serial_out_line_o <= 1'b0;
        end else if (in_frame && sclk_fall) begin
            shift_r <= {shift_r[30:0], serin_s};
            if (count_r != `CNT_MAX)
                count_r <= count_r + 6'd1;
            serial_out_line_o <= out_r[23];
            out_r <= {out_r[22:0], 1'b0};
        end
    end

    // Command execution; hardware-set fault bits win over clears
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            dac_r <= `DAC_RST;
            ctrl_r <= `CTRL_RST;
            offs_r <= `OFFS_RST;
            gain_r <= `GAIN_RST;
            rd_word_r <= 16'h0000;
            rd_pend_r <= 1'b0;
            crc_err_r <= 1'b0;
            dac_code_o <= `DAC_RST;
            offset_active_o <= `OFFS_RST;
            gain_active_o <= `GAIN_RST;
            alarm_o <= 1'b1;
            adc_start_o <= 1'b0;
        end else begin
            adc_start_o <= 1'b0;
            if (sync_rise)
                rd_pend_r <= 1'b0;
            if (frame_ok) begin
                case (cmd)
                    `CMD_WR_DAC: begin
                        dac_r <= data;
                        dac_code_o <= data;
                        offset_active_o <= offs_r;
                        gain_active_o <= gain_r;
                        alarm_o <= 1'b0;
                    end
                    `CMD_WR_CTRL: ctrl_r <= data;
                    `CMD_WR_OFFS: offs_r <= data;
                    `CMD_WR_GAIN: gain_r <= data;
                    // Data word unused by the action commands below
                    `CMD_LOAD_DAC: begin
                        dac_code_o <= dac_r;
                        alarm_o <= 1'b0;
                    end
                    `CMD_FORCE_ALARM: alarm_o <= 1'b1;
                    `CMD_RESET: begin
                        dac_r <= `DAC_RST;
                        ctrl_r <= `CTRL_RST;
                        offs_r <= `OFFS_RST;
                        gain_r <= `GAIN_RST;
                        dac_code_o <= `DAC_RST;
                        offset_active_o <= `OFFS_RST;
                        gain_active_o <= `GAIN_RST;
                        alarm_o <= 1'b1;
                    end
                    `CMD_MEASURE: adc_start_o <= 1'b1;
                    default: ;
                endcase
                // Fault register has no write path
                if (is_read) begin
                    rd_word_r <= rd_sel;
                    rd_pend_r <= 1'b1;
                end
                // Auto readback converts once per frame when powered
                if (!ctrl_r[`CTRL_AUTO_RB_DIS] && ctrl_r[`CTRL_ADC_PWR])
                    adc_start_o <= 1'b1;
            end
            // Sticky link faults clear only on the reset command
            if (crc_bad)
                crc_err_r <= 1'b1;
            else if (frame_ok && cmd == `CMD_RESET)
                crc_err_r <= 1'b0;
        end
    end

    // ADC result capture and mode outputs
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            adc_r <= 8'h00;
            ctrl_o <= `CTRL_RST;
            adc_power_o <= 1'b0;
            adc_source_o <= 1'b0;
        end else begin
            if (adc_done)
                adc_r <= adc_s;
            ctrl_o <= ctrl_r;
            adc_power_o <= ctrl_r[`CTRL_ADC_PWR] | start_nxt;
            adc_source_o <= ctrl_r[`CTRL_ADC_SEL];
        end
    end

    // Serial watchdog; any frame start restarts it. A sync glitch still
    // counts as traffic, which favours keeping the fault quiet.
    // The count saturates, so a silent link holds the fault without wrapping.
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            wdog_cnt_r <= {`WDOG_W{1'b0}};
            wdog_r <= 1'b0;
            fault_o <= 1'b0;
        end else begin
            if (sync_fall)
                wdog_cnt_r <= {`WDOG_W{1'b0}};
            else if (wdog_cnt_r != WDOG_CYCLES)
                wdog_cnt_r <= wdog_cnt_r + {{(`WDOG_W-1){1'b0}}, 1'b1};
            if (!sync_fall && wdog_cnt_r == WDOG_CYCLES - {{(`WDOG_W-1){1'b0}}, 1'b1})
                wdog_r <= 1'b1;
            else if (frame_ok && cmd == `CMD_RESET)
                wdog_r <= 1'b0;
            fault_o <= wdog_r | crc_err_r | (|flags_s);
        end
    end

endmodule // dac_cmd_port

/* File: logic/dac_port_defines.vh */
/*
 * Constants for the serial command port of the loop-current DAC:
 * frame layout, command bytes, control bit positions,
 * reset values and the watchdog period.
 * Assumes it is included by bare name into the design file only.
 */
`ifndef DAC_PORT_DEFINES_VH
`define DAC_PORT_DEFINES_VH

// Frame lengths and field positions
`define FRAME_BITS 6'd24
`define FRAME_CRC_BITS 6'd32
`define CNT_MAX 6'd33
`define CMD_HI 23
`define CMD_LO 16
`define DATA_HI 15
`define DATA_LO 0
`define CRC_POLY 8'h07
`define CRC_INIT 8'h00

// Command bytes; reads set the top bit over the write address, the fault read over the load command
`define CMD_WR_DAC 8'h01
`define CMD_WR_CTRL 8'h02
`define CMD_WR_OFFS 8'h03
`define CMD_WR_GAIN 8'h04
`define CMD_LOAD_DAC 8'h05
`define CMD_FORCE_ALARM 8'h06
`define CMD_RESET 8'h07
`define CMD_MEASURE 8'h08
`define CMD_NOP 8'h09
`define CMD_RD_DAC 8'h81
`define CMD_RD_CTRL 8'h82
`define CMD_RD_OFFS 8'h83
`define CMD_RD_GAIN 8'h84
`define CMD_RD_FAULT 8'h85

// Control register fields
`define CTRL_AUTO_RB_DIS 11
`define CTRL_ADC_SEL 8
`define CTRL_ADC_PWR 7

// Reset values
`define DAC_RST 16'h0000
`define CTRL_RST 16'h0000
`define OFFS_RST 16'h8000
`define GAIN_RST 16'hffff

// Serial watchdog: one second at the 100 MHz reference, sized to the counter
`define WDOG_W 27
`define WDOG_CYCLES 27'h5f5e100

`endif

/* File: sim/dac_cmd_port_sva.sv */
/* Pin checker for the DAC command port.
   Assumes a bind onto dac_cmd_port, pins sampled by ref_clk_i. */
`timescale 1ns/1ps
module dac_cmd_port_sva #(
    parameter int WDOG_CYCLES = 100000000
) (
    input wire ref_clk_i,
    input wire rst_i,
    input wire sclk_i,
    input wire sync_n_i,
    input wire serial_out_line_o,
    input wire fault_o,
    input wire [15:0] dac_code_o,
    input wire [15:0] offset_active_o,
    input wire [15:0] gain_active_o,
    input wire [15:0] ctrl_o,
    input wire adc_start_o,
    input wire adc_power_o,
    input wire adc_source_o
);
    logic [5:0] end_cnt_r;
    logic [5:0] edge_cnt_r;
    logic [31:0] idle_cnt_r;
    // Ages of last frame end, link edge and frame start; saturate so they never wrap
    always @(posedge ref_clk_i) begin
        if (rst_i || $rose(sync_n_i))
            end_cnt_r <= {6{rst_i}};
        else if (~&end_cnt_r)
            end_cnt_r <= end_cnt_r + 6'h01;
        if (rst_i || $fell(sclk_i) || $changed(sync_n_i))
            edge_cnt_r <= {6{rst_i}};
        else if (~&edge_cnt_r)
            edge_cnt_r <= edge_cnt_r + 6'h01;
        if (rst_i || $fell(sync_n_i))
            idle_cnt_r <= 32'h0;
        else if (idle_cnt_r < WDOG_CYCLES + 8)
            idle_cnt_r <= idle_cnt_r + 32'h1;
    end
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    // Register effects land a few cycles after frame-sync rises
    sequence s_done; end_cnt_r <= 6'd6; endsequence
    sequence s_strobe; adc_start_o ##1 !adc_start_o; endsequence
    property p_dac; $changed(dac_code_o) |-> s_done; endproperty
    property p_ctrl; $changed(ctrl_o) |-> s_done; endproperty
    property p_trim; $changed({offset_active_o, gain_active_o}) |-> s_done; endproperty
    property p_strobe; $rose(adc_start_o) |-> s_done ##0 s_strobe; endproperty
    property p_power; adc_start_o |-> adc_power_o; endproperty
    property p_source; $changed(adc_source_o) |-> ##[0:2] adc_source_o == ctrl_o[8]; endproperty
    property p_sout; $changed(serial_out_line_o) |-> edge_cnt_r <= 6'd6; endproperty
    property p_wdog; idle_cnt_r >= WDOG_CYCLES + 8 |-> fault_o; endproperty
    a_dac: assert property (p_dac) else $error("dac code moved off frame end");
    a_ctrl: assert property (p_ctrl) else $error("ctrl moved off frame end");
    a_trim: assert property (p_trim) else $error("trim moved off frame end");
    a_strobe: assert property (p_strobe) else $error("bad adc start pulse");
    a_power: assert property (p_power) else $error("adc started unpowered");
    a_source: assert property (p_source) else $error("adc source not ctrl");
    a_sout: assert property (p_sout) else $error("readback moved off edge");
    a_wdog: assert property (p_wdog) else $error("watchdog fault missing");
endmodule // dac_cmd_port_sva

bind dac_cmd_port dac_cmd_port_sva #(.WDOG_CYCLES(WDOG_CYCLES)) u_sva (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .sclk_i(sclk_i), .sync_n_i(sync_n_i),
    .serial_out_line_o(serial_out_line_o), .fault_o(fault_o), .dac_code_o(dac_code_o),
    .offset_active_o(offset_active_o), .gain_active_o(gain_active_o), .ctrl_o(ctrl_o),
    .adc_start_o(adc_start_o), .adc_power_o(adc_power_o), .adc_source_o(adc_source_o));

/* File: sim/host_model.sv */
/* Host side of the serial link: frame-sync, serial clock, data, readback.
   Assumes the port samples data on serial clock falls. */
`timescale 1ns/1ps
module host_model (
    input wire ref_clk_i,
    output logic sclk_o,
    output logic sync_n_o,
    output logic ser_in_o,
    input wire ser_out_i
);
    // Clock idles high and stands still between frames unless send adds free pulses
    initial begin
        sclk_o = 1'b1;
        sync_n_o = 1'b1;
        ser_in_o = 1'b0;
    end
    // One 125 ns clock period, well inside the rate limit
    task automatic tick(output logic smp);
        #62.5 sclk_o = 1'b0;
        #62.0 smp = ser_out_i;
        #0.5 sclk_o = 1'b1;
    endtask
    // Sends nbits MSB first; free adds clock pulses outside the frame
    task automatic send(input logic [31:0] frame, input int nbits, input bit free,
                        output logic [23:0] rx);
        logic smp;
        @(posedge ref_clk_i);
        #1;
        if (free) repeat (2) tick(smp);
        sync_n_o = 1'b0;
        for (int i = nbits - 1; i >= 0; i--) begin
            ser_in_o = frame[i];
            tick(smp);
            rx = {rx[22:0], smp};
        end
        #62.5 sync_n_o = 1'b1;
        // Released line shows the inverse so a stale level cannot pass
        ser_in_o = ~ser_in_o;
        if (free) repeat (2) tick(smp);
        repeat (8) @(posedge ref_clk_i);
        #1;
    endtask
endmodule // host_model

/* File: sim/tb_top.sv */
/* Bench for dac_cmd_port: table of frames, then readback, reset, framing,
   CRC and watchdog cases. Assumes host_model drives the serial pins. */
`timescale 1ns/1ps
module tb_top;
    typedef struct packed {logic [23:0] frame; logic [15:0] dac, ctrl, gain; logic alarm;} row_t;
    logic ref_clk_i;
    logic rst_i = 1'b1;
    logic adc_done = 1'b0;
    logic [5:0] flags = 6'h00;
    logic [7:0] adc_code = 8'h00;
    logic sclk, sync_n, ser_in, sout, fault, alarm, start, power, source;
    logic [15:0] dac, offs, gain, ctrl;
    logic [23:0] rx;
    int errors = 0;
    int n_tests = 0;
    int n_start = 0;
    int mark = 0;
    // Frame, then the DAC, control and gain words and alarm it leaves
    row_t rows [10] = '{
        '{24'h011234, 16'h1234, 16'h0000, 16'hffff, 1'b0},
        '{24'h020180, 16'h1234, 16'h0180, 16'hffff, 1'b0},
        '{24'h08ffff, 16'h1234, 16'h0180, 16'hffff, 1'b0},
        '{24'h06ffff, 16'h1234, 16'h0180, 16'hffff, 1'b1},
        '{24'h05ffff, 16'h1234, 16'h0180, 16'hffff, 1'b0},
        '{24'h09ffff, 16'h1234, 16'h0180, 16'hffff, 1'b0},
        '{24'h04abcd, 16'h1234, 16'h0180, 16'hffff, 1'b0},
        '{24'h81ffff, 16'h1234, 16'h0180, 16'hffff, 1'b0},
        '{24'h01ffff, 16'hffff, 16'h0180, 16'habcd, 1'b0},
        '{24'h07ffff, 16'h0000, 16'h0000, 16'hffff, 1'b1}};
    host_model host (.ref_clk_i(ref_clk_i), .sclk_o(sclk), .sync_n_o(sync_n),
        .ser_in_o(ser_in), .ser_out_i(sout));
    dac_cmd_port #(.WDOG_CYCLES(27'd2000)) dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .sclk_i(sclk), .sync_n_i(sync_n), .serial_in_line_i(ser_in), .fault_flags_i(flags),
        .adc_code_i(adc_code), .adc_done_i(adc_done), .serial_out_line_o(sout),
        .fault_o(fault), .dac_code_o(dac), .offset_active_o(offs), .gain_active_o(gain),
        .ctrl_o(ctrl), .alarm_o(alarm), .adc_start_o(start), .adc_power_o(power),
        .adc_source_o(source));
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic [23:0] f);
        host.send({8'h00, f}, 24, 1'b0, rx);
    endtask
    // Check byte over the 24 frame bits, MSB first
    function automatic logic [7:0] crc8(input logic [23:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 23; i >= 0; i--)
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
        return c;
    endfunction
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end
    // Counts conversion strobes so that single-cycle pulses are not missed
    always @(posedge ref_clk_i)
        if (start === 1'b1)
            n_start <= n_start + 1;
    // Cuts a hang short
    initial begin
        #900000;
        errors++;
        final_report();
    end
    initial begin
        repeat (2) @(posedge ref_clk_i);
        #1 rst_i = 1'b0;
        repeat (4) @(posedge ref_clk_i);
        foreach (rows[i]) begin
            xfer(rows[i].frame);
            check({dac, ctrl, gain}, {rows[i].dac, rows[i].ctrl, rows[i].gain});
            check({alarm, power, source},
                {rows[i].alarm, rows[i].ctrl[7], rows[i].ctrl[8]});
            $display("row %0d done", i);
        end
        // Offset waits for a DAC write; read data comes out on the next frame
        xfer(24'h020800);
        xfer(24'h037000);
        check(offs, 16'h8000);
        xfer(24'h83aaaa);
        xfer(24'h010100);
        check({rx, offs}, {24'h007000, 16'h7000});
        // Each read answers in the frame after it: control, gain, then DAC
        xfer(24'h82aaaa);
        xfer(24'h84aaaa);
        check(rx, 24'h000800);
        xfer(24'h81aaaa);
        check(rx, 24'h00ffff);
        xfer(24'h090000);
        check(rx, 24'h000100);
        $display("offset readback done");
        #1 rst_i = 1'b1;
        repeat (2) @(posedge ref_clk_i);
        #1 rst_i = 1'b0;
        check({dac, offs, gain, ctrl}, 64'h0000_8000_ffff_0000);
        check({alarm, fault, sout, start, power}, 5'h10);
        $display("reset done");
        flags = 6'h2a;
        adc_code = 8'h5c;
        repeat (4) @(posedge ref_clk_i);
        #1 adc_done = 1'b1;
        xfer(24'h020800);
        // One strobe for a measure command with the ADC otherwise unpowered
        mark = n_start;
        xfer(24'h080000);
        check({n_start - mark, power}, {32'd1, 1'b0});
        xfer(24'h85ffff);
        xfer(24'h090000);
        check({rx, fault}, {24'h002a5c, 1'b1});
        flags = 6'h00;
        adc_done = 1'b0;
        $display("fault read done");
        host.send({8'h00, 24'h014321}, 23, 1'b0, rx);
        check(dac, 16'h0000);
        host.send({24'h01abcd, crc8(24'h01abcd)}, 32, 1'b1, rx);
        check({dac, fault}, {16'habcd, 1'b0});
        host.send({24'h015555, ~crc8(24'h015555)}, 32, 1'b0, rx);
        xfer(24'h85ffff);
        xfer(24'h090000);
        check({dac, fault, rx}, {16'habcd, 1'b1, 24'h00805c});
        $display("framing done");
        // Staircase of DAC writes: each code takes effect at the end of its own frame
        for (int k = 1; k <= 3; k++) begin
            xfer({8'h01, 4'(k), 12'h000});
            check(dac, {4'(k), 12'h000});
        end
        $display("staircase done");
        xfer(24'h07ffff);
        repeat (2100) @(posedge ref_clk_i);
        #1;
        check(fault, 1'b1);
        xfer(24'h090000);
        check(rx[23:14], 10'h001);
        $display("watchdog done");
        final_report();
    end
endmodule // tb_top
